//--- hdl/ict_timer.v
// Interval countdown timer with APB register access.
// Assumes one 100 MHz clock, synchronous reset, an APB master
// on the same clock.
//
// What this block does
// R01: 32-bit down counter, preload from two halves
// R02: registers 16 bits; period set by two writes
// R03: one clock drives registers and counter
// R04: expiry flag sets at zero, sticky
// R05: any status write clears expiry only
// R06: active flag shows counter is counting
// R07: control bits: ie, repeat, start, stop
// R08: interrupt equals expiry AND enable
// R09: zero reached while counting reloads period value
// R10: repeat cycles; otherwise stop after reload unless free-running or watchdog started
// R11: writing start one starts counting
// R12: writing stop one halts counter
// R13: free-running ignores stop writes
// R14: software never writes start and stop together
// R15: counter holds zero one clock before reload
// R16: period write loads counter with period
// R17: period write stops counter unless free-running or watchdog started
// R18: free-running period write keeps counter running
// R19: fixed-period write reloads counter with fixed preload
// R20: snapshot write captures whole counter at once
// R21: snapshot allowed anytime, never disturbs counting
// R22: snapshot low/high halves of sampled count
// R23: period low/high halves of preload
// R24: watchdog pulses reset request at zero
// R25: watchdog idle after reset, unstoppable once started
// R26: timeout pulse output one clock at expiry
// R27: decrement each clock; idle after reset unless free-running without watchdog
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "ict_defines.vh"

module ict_timer #(
    parameter FREE_RUN = 0,
    parameter FIXED_PERIOD = 0,
    parameter WATCHDOG = 0,
    parameter TIMEOUT_PULSE = 0,
    parameter [31:0] FIXED_PRELOAD = 32'h000003E7
) (
    input wire REF_CLK_IN,
    input wire RST_IN,
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire PWRITE_IN,
    input wire [`ICT_ADDR_W-1:0] PADDR_IN,
    input wire [`ICT_DATA_W-1:0] PWDATA_IN,
    output wire [`ICT_DATA_W-1:0] PRDATA_OUT,
    output wire PREADY_OUT,
    output wire PSLVERR_OUT,
    output wire IRQ_OUT,
    output wire RESET_REQ_OUT,
    output wire TIMEOUT_PULSE_OUT
);

////////////////////////////////////////////////////////////////
// Address decode

function ict_mapped;
    input [`ICT_ADDR_W-1:0] addr;
    begin
        ict_mapped = (addr[1:0] == 2'h0) &&
            (addr[`ICT_ADDR_W-1:2] <= {7'h00, `ICT_IDX_SNAP_HI});
    end
endfunction

function ict_hit;
    input [`ICT_ADDR_W-1:0] addr;
    input [2:0] idx;
    begin
        ict_hit = (addr[1:0] == 2'h0) &&
            (addr[`ICT_ADDR_W-1:2] == {7'h00, idx});
    end
endfunction

localparam [31:0] RST_PERIOD_V =
    (FIXED_PERIOD != 0) ? FIXED_PRELOAD : `ICT_RST_PERIOD;
localparam RST_RUN_V = (FREE_RUN != 0) && (WATCHDOG == 0);

////////////////////////////////////////////////////////////////
// State

reg [31:0] count_r;
reg [31:0] count_nxt;
reg run_r;
reg run_nxt;
reg started_r;
reg expiry_r;
reg ie_r;
reg repeat_r;
reg start_bit_r;
reg stop_bit_r;
reg [31:0] period_r;
reg [31:0] period_nxt;
reg [31:0] snap_r;
reg [`ICT_DATA_W-1:0] prdata_r;
reg reset_req_r;
reg timeout_r;

wire access = PSEL_IN & PENABLE_IN;
wire wr = access & PWRITE_IN;
wire wr_status = wr & ict_hit(PADDR_IN, `ICT_IDX_STATUS);
wire wr_ctrl = wr & ict_hit(PADDR_IN, `ICT_IDX_CONTROL);
wire wr_plo = wr & ict_hit(PADDR_IN, `ICT_IDX_PERIOD_LO);
wire wr_phi = wr & ict_hit(PADDR_IN, `ICT_IDX_PERIOD_HI);
wire wr_period = wr_plo | wr_phi;
wire wr_snap = wr & (ict_hit(PADDR_IN, `ICT_IDX_SNAP_LO) |
    ict_hit(PADDR_IN, `ICT_IDX_SNAP_HI));
wire start_ev = wr_ctrl & PWDATA_IN[`ICT_CT_START];
wire stop_ev = wr_ctrl & PWDATA_IN[`ICT_CT_STOP];

// Counter is never halted in free-run or once a watchdog starts
wire no_stop = (FREE_RUN != 0) || ((WATCHDOG != 0) && started_r); // R13 R25

// Zero reached while counting
wire expire_ev = run_r & (count_r == 32'h00000000); // R04 R15

////////////////////////////////////////////////////////////////
// Period and counter next values

always @*
begin
    period_nxt = period_r;
    if (FIXED_PERIOD == 0)
    begin
        if (wr_plo)
            period_nxt[15:0] = PWDATA_IN[15:0]; // R02 R23
        if (wr_phi)
            period_nxt[31:16] = PWDATA_IN[15:0]; // R02 R23
    end
end

always @*
begin
    count_nxt = count_r;
    run_nxt = run_r;
    if (expire_ev)
    begin
        count_nxt = period_r; // R09
        if (!repeat_r && !no_stop)
            run_nxt = 1'b0; // R10
    end
    else if (run_r)
    begin
        count_nxt = count_r - 32'h00000001; // R27 R01
    end
    if (start_ev)
        run_nxt = 1'b1; // R11
    if (stop_ev && !no_stop)
        run_nxt = 1'b0; // R12 R13
    if (wr_period)
    begin
        if (FIXED_PERIOD != 0)
            count_nxt = FIXED_PRELOAD; // R19
        else
            count_nxt = period_nxt; // R16
        if (!no_stop)
            run_nxt = 1'b0; // R17
        // Free-running leaves the active state as it was
        else
            run_nxt = run_r | start_ev; // R18
    end
end

////////////////////////////////////////////////////////////////
// Registers, all on the single master clock

always @(posedge REF_CLK_IN) // R03
begin
    if (RST_IN)
    begin
        count_r <= RST_PERIOD_V;
        run_r <= RST_RUN_V; // R25 R27
        started_r <= 1'b0;
        expiry_r <= 1'b0; // R27
        ie_r <= 1'b0;
        repeat_r <= 1'b0;
        start_bit_r <= 1'b0;
        stop_bit_r <= 1'b0;
        period_r <= RST_PERIOD_V;
        snap_r <= `ICT_RST_SNAP;
        reset_req_r <= 1'b0;
        timeout_r <= 1'b0;
    end
    else
    begin
        count_r <= count_nxt;
        run_r <= run_nxt;
        if (start_ev)
            started_r <= 1'b1;
        // Set wins over the clear
        if (expire_ev)
            expiry_r <= 1'b1; // R04
        else if (wr_status)
            expiry_r <= 1'b0; // R05
        if (wr_ctrl)
        begin
            ie_r <= PWDATA_IN[`ICT_CT_IE]; // R07
            repeat_r <= PWDATA_IN[`ICT_CT_REPEAT]; // R07
            start_bit_r <= PWDATA_IN[`ICT_CT_START]; // R07
            stop_bit_r <= PWDATA_IN[`ICT_CT_STOP]; // R07
        end
        period_r <= period_nxt;
        if (wr_snap)
            snap_r <= count_r; // R20 R21
        reset_req_r <= (WATCHDOG != 0) && expire_ev; // R24
        timeout_r <= (TIMEOUT_PULSE != 0) && expire_ev; // R26
    end
end

////////////////////////////////////////////////////////////////
// Read data, captured in the setup cycle

always @(posedge REF_CLK_IN)
begin
    if (RST_IN)
        prdata_r <= 32'h00000000;
    else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN)
    begin
        prdata_r <= 32'h00000000;
        case (PADDR_IN)
            {7'h00, `ICT_IDX_STATUS, 2'h0}:
                prdata_r[1:0] <= {run_r, expiry_r}; // R06
            {7'h00, `ICT_IDX_CONTROL, 2'h0}:
                prdata_r[3:0] <= {stop_bit_r, start_bit_r, repeat_r, ie_r};
            {7'h00, `ICT_IDX_PERIOD_LO, 2'h0}:
                prdata_r[15:0] <= period_r[15:0]; // R23
            {7'h00, `ICT_IDX_PERIOD_HI, 2'h0}:
                prdata_r[15:0] <= period_r[31:16]; // R23
            {7'h00, `ICT_IDX_SNAP_LO, 2'h0}:
                prdata_r[15:0] <= snap_r[15:0]; // R22
            {7'h00, `ICT_IDX_SNAP_HI, 2'h0}:
                prdata_r[15:0] <= snap_r[31:16]; // R22
            default:
                prdata_r <= 32'h00000000;
        endcase
    end
end

////////////////////////////////////////////////////////////////
// Outputs

assign PRDATA_OUT = prdata_r;
assign PREADY_OUT = PSEL_IN & PENABLE_IN;
assign PSLVERR_OUT = access & ~ict_mapped(PADDR_IN);
assign IRQ_OUT = expiry_r & ie_r; // R08
assign RESET_REQ_OUT = reset_req_r;
assign TIMEOUT_PULSE_OUT = timeout_r;

endmodule // ict_timer

//--- pkg/ict_defines.vh
// Constants of the interval countdown timer: register indices,
// field positions, reset values.
// Assumes inclusion by bare name from the design files.
`ifndef ICT_DEFINES_VH
`define ICT_DEFINES_VH

// Register indices; byte address is four times the index
`define ICT_IDX_STATUS 3'h0
`define ICT_IDX_CONTROL 3'h1
`define ICT_IDX_PERIOD_LO 3'h2
`define ICT_IDX_PERIOD_HI 3'h3
`define ICT_IDX_SNAP_LO 3'h4
`define ICT_IDX_SNAP_HI 3'h5

// Bus widths
`define ICT_ADDR_W 12
`define ICT_DATA_W 32
`define ICT_REG_W 16

// Status fields
`define ICT_ST_EXPIRY 0
`define ICT_ST_ACTIVE 1

// Control fields
`define ICT_CT_IE 0
`define ICT_CT_REPEAT 1
`define ICT_CT_START 2
`define ICT_CT_STOP 3

// Reset values
`define ICT_RST_CTRL 4'h0
`define ICT_RST_PERIOD 32'h00000000
`define ICT_RST_SNAP 32'h00000000

`endif

//--- sim/ict_apb_host.sv
// Processor side: APB master issuing one whole transfer per call.
// Assumes a zero or more wait state slave on the same clock.
`timescale 1ns/1ps
module ict_apb_host (
    input wire logic clk_in,
    input wire logic pready_in,
    input wire logic pslverr_in,
    input wire logic [31:0] prdata_in,
    output logic psel_out = 1'h0,
    output logic penable_out = 1'h0,
    output logic pwrite_out = 1'h0,
    output logic [11:0] paddr_out = 12'h0,
    output logic [31:0] pwdata_out = 32'h0
);
    // Each register half is a transfer of its own
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge clk_in);
        psel_out <= 1'h1;
        pwrite_out <= w;
        paddr_out <= a;
        pwdata_out <= d;
        @(posedge clk_in);
        penable_out <= 1'h1;
        @(posedge clk_in);
        while (pready_in !== 1'h1)
            @(posedge clk_in);
        q = prdata_in;
        e = pslverr_in;
        psel_out <= 1'h0;
        penable_out <= 1'h0;
        pwdata_out <= ~d;
    endtask
endmodule // ict_apb_host

//--- sim/ict_timer_chk.sv
// Port assertions for the interval countdown timer.
// Assumes bind to ict_timer; pulse output option passed in.
`timescale 1ns/1ps
module ict_timer_chk #(
    parameter TIMEOUT_PULSE = 0
) (
    input wire REF_CLK_IN,
    input wire RST_IN,
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire PWRITE_IN,
    input wire [11:0] PADDR_IN,
    input wire [31:0] PRDATA_OUT,
    input wire PREADY_OUT,
    input wire PSLVERR_OUT,
    input wire IRQ_OUT,
    input wire TIMEOUT_PULSE_OUT
);
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (RST_IN);
    wire acc = PSEL_IN && PENABLE_IN;
    wire wr_lo = acc && PWRITE_IN && PADDR_IN < 12'h008;
    ////////////////////////////////////////////////////////////////
    bus_ready_a: assert property (PREADY_OUT == acc) else $error("ready");
    err_map_a: assert property (acc |-> PSLVERR_OUT == (PADDR_IN[1:0] != 2'h0
        || PADDR_IN > 12'h014)) else $error("err map");
    err_idle_a: assert property (!acc |-> !PSLVERR_OUT) else $error("err idle");
    rd_upper_a: assert property (PRDATA_OUT[31:16] == 16'h0) else $error("upper");
    irq_fall_a: assert property ($fell(IRQ_OUT) |-> $past(wr_lo) || $past(RST_IN))
        else $error("irq fall");
    irq_rise_a: assert property ($rose(IRQ_OUT) && TIMEOUT_PULSE |->
        TIMEOUT_PULSE_OUT || $past(wr_lo)) else $error("irq rise");
    pulse_one_a: assert property (TIMEOUT_PULSE_OUT |=> !TIMEOUT_PULSE_OUT)
        else $error("pulse");
    rst_quiet_a: assert property (disable iff (1'h0) RST_IN |=> !IRQ_OUT
        && !TIMEOUT_PULSE_OUT && PRDATA_OUT == 32'h0) else $error("reset");
endmodule // ict_timer_chk
bind ict_timer ict_timer_chk #(.TIMEOUT_PULSE(TIMEOUT_PULSE)) ict_timer_chk_i (.*);

//--- sim/testbench.sv
// Self-checking bench for the interval countdown timer.
// Assumes the APB host model and checker are compiled alongside.
`timescale 1ns/1ps
module testbench;
    logic clk = 1'h0;
    logic rst = 1'h1;
    integer n_fail = 0;
    integer total_checks = 0;
    integer cyc = 0;
    integer i, k;
    logic [31:0] q, s;
    logic e;
    logic [15:0] n, h;
    wire psel, pen, pwr, rdy, err, irq, tp, rr;
    wire [11:0] pa;
    wire [31:0] pwd, prd;
    initial forever #5 clk = ~clk;
    ict_apb_host ict_apb_host_i (.clk_in(clk), .pready_in(rdy), .pslverr_in(err),
        .prdata_in(prd), .psel_out(psel), .penable_out(pen), .pwrite_out(pwr),
        .paddr_out(pa), .pwdata_out(pwd));
    ict_timer #(.TIMEOUT_PULSE(1)) ict_timer_i (.REF_CLK_IN(clk), .RST_IN(rst),
        .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa),
        .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(rdy), .PSLVERR_OUT(err),
        .IRQ_OUT(irq), .RESET_REQ_OUT(rr), .TIMEOUT_PULSE_OUT(tp));
    ////////////////////////////////////////////////////////////////
    task close_out;
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x)
        begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, g, x);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        ict_apb_host_i.xfer(1'h1, a, d, q, e);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] x);
        ict_apb_host_i.xfer(1'h0, a, 32'h0, q, e);
        chk(q, x);
    endtask
    // Edges until the next expiry pulse, bounded
    task wp(output integer c);
        c = 0;
        @(posedge clk);
        while (tp !== 1'h1 && c < 500)
        begin
            @(posedge clk);
            c++;
        end
    endtask
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            close_out;
        end
    end
    ////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'hFB1A));
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        for (i = 0; i < 24; i += 4)
            rd(12'(i), 32'h0);
        n = 16'h20 + 16'($urandom % 32);
        h = 16'($urandom);
        wr(12'h00C, {16'h0, h});
        wr(12'h008, {16'h0, n});
        wr(12'h010, 32'h0);
        rd(12'h010, {16'h0, n});
        rd(12'h014, {16'h0, h});
        rd(12'h00C, {16'h0, h});
        rd(12'h000, 32'h0);
        wr(12'h00C, 32'h0);
        wr(12'h004, 32'h7);
        rd(12'h000, 32'h2);
        wp(k);
        wp(k);
        chk(32'(k), 32'(n));
        chk(32'(irq), 32'h1);
        wr(12'h000, 32'hFFFF);
        @(posedge clk);
        chk(32'(irq), 32'h0);
        rd(12'h000, 32'h2);
        wr(12'h004, 32'h9);
        rd(12'h000, 32'h0);
        wr(12'h010, 32'h0);
        ict_apb_host_i.xfer(1'h0, 12'h010, 32'h0, q, e);
        s = q;
        wr(12'h014, 32'h0);
        rd(12'h010, s);
        rd(12'h014, 32'h0);
        wr(12'h004, 32'h5);
        rd(12'h004, 32'h5);
        wp(k);
        rd(12'h000, 32'h1);
        wr(12'h014, 32'h0);
        rd(12'h010, {16'h0, n});
        ict_apb_host_i.xfer(1'h1, 12'h018, $urandom, q, e);
        chk(32'(e), 32'h1);
        chk(32'(rr), 32'h0);
        close_out;
    end
endmodule // testbench
